// File: design/sac_pkg.sv
// constants shared by the serial attenuation control port
package sac_pkg;
  localparam int          WORD_W        = 6;
  localparam int          CNT_W         = 3;
  localparam logic [5:0]  WORD_RESET    = 6'h00; // all-zeros preset
  localparam logic [5:0]  ATTEN_MAX     = 6'h3B; // 29.5 dB in half-dB units
  localparam logic [5:0]  SAT_CODE      = 6'h04; // lowest usable code
  localparam logic [2:0]  CNT_LAST      = 3'h5;  // index of sixth bit
  localparam logic [2:0]  CNT_FULL      = 3'h6;  // frame holds six bits
  localparam logic [2:0]  CNT_ZERO      = 3'h0;
  localparam int          SYNC_W        = 3;
  localparam real         CORE_PERIOD_NS = 5.0;
  typedef enum logic {SAC_IDLE, SAC_PEND} sac_state_t;
endpackage

// File: design/sac_sync2.sv
// two flip-flop level synchroniser, one stage pair per bit
module sac_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // =====================================================
  // synchroniser stages
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta[g]   <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          meta[g]   <= async_i[g];
          sync_o[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule

// File: design/sac_top.sv
// serial attenuation control port: link shifter and core word register
// What this block does
// - a transfer carries six bits, most significant first, shifted in order
// - cleared bits add 0.5 to 16 dB binary weights; all ones is 0 dB
// - codes below 000100 saturate at the 29.5 dB maximum
// - power enable low turns amplifier off; serial logic keeps running
// - before any write the word is all zeros, maximum attenuation
// - clock ignored while select high; word applied on select rising edge
// - words still latch during standby and show when re-enabled
module sac_top
  import sac_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      serial_clk_i,
  input  wire logic                      serial_data_i,
  input  wire logic                      select_bar_input_i,
  input  wire logic                      power_enable_input_i,
  output logic [sac_pkg::WORD_W-1:0]     atten_word_o,
  output logic [sac_pkg::WORD_W-1:0]     atten_half_db_o,
  output logic                           amp_on_o
);
  import sac_pkg::*;

  // =====================================================
  // link domain: shifter on the serial clock
  logic              frame_rst_n;
  logic [WORD_W-1:0] shift;
  logic [CNT_W-1:0]  bit_cnt;
  logic [WORD_W-1:0] next_shift;
  logic [CNT_W-1:0]  next_bit_cnt;
  logic [WORD_W-1:0] hold_word;
  logic              hold_tog;
  logic [WORD_W-1:0] next_hold_word;
  logic              next_hold_tog;

  // select high holds the frame state cleared, so clock edges do nothing
  assign frame_rst_n = resetn_i & ~select_bar_input_i;

  // next shift state; bits past the sixth are dropped
  always_comb begin
    next_shift     = shift;
    next_bit_cnt   = bit_cnt;
    next_hold_word = hold_word;
    next_hold_tog  = hold_tog;
    if (bit_cnt != CNT_FULL) begin
      next_shift   = {shift[WORD_W-2:0], serial_data_i};
      next_bit_cnt = bit_cnt + 3'h1;
    end
    // sixth bit completes a word: hand it over with a toggle
    if (bit_cnt == CNT_LAST && frame_rst_n) begin
      next_hold_word = {shift[WORD_W-2:0], serial_data_i};
      next_hold_tog  = ~hold_tog;
    end
  end

  // frame registers, cleared by select high
  always_ff @(posedge serial_clk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift   <= WORD_RESET;
      bit_cnt <= CNT_ZERO;
    end else begin
      shift   <= next_shift;
      bit_cnt <= next_bit_cnt;
    end
  end

  // hand-over registers survive between frames
  always_ff @(posedge serial_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_word <= WORD_RESET;
      hold_tog  <= 1'b0;
    end else begin
      hold_word <= next_hold_word;
      hold_tog  <= next_hold_tog;
    end
  end

  // =====================================================
  // crossing into the core domain
  logic [SYNC_W-1:0] sync_out;
  logic              sel_s;
  logic              tog_s;
  logic              pwr_s;

  sac_sync2 #(.WIDTH(SYNC_W)) u_sync (
    .clk_i    (core_clk_i),
    .resetn_i (resetn_i),
    .async_i  ({select_bar_input_i, hold_tog, power_enable_input_i}),
    .sync_o   (sync_out)
  );

  assign sel_s = sync_out[2];
  assign tog_s = sync_out[1];
  assign pwr_s = sync_out[0];

  // =====================================================
  // core domain: pending word and applied word
  sac_state_t        state;
  sac_state_t        next_state;
  logic              sel_q;
  logic              tog_q;
  logic [WORD_W-1:0] pend_word;
  logic [WORD_W-1:0] next_pend_word;
  logic [WORD_W-1:0] next_word;
  logic [WORD_W-1:0] next_half_db;
  logic [WORD_W-1:0] inv_word;
  logic              sel_rise;
  logic              word_seen;

  assign sel_rise = sel_s & ~sel_q;

  // a complete word waits until select rises, then is applied
  always_comb begin
    next_state     = state;
    next_pend_word = pend_word;
    next_word      = atten_word_o;
    inv_word       = WORD_RESET;
    case (state)
      SAC_IDLE: begin
        if (tog_s != tog_q) begin
          next_pend_word = hold_word; // stable: changes six edges later
          next_state     = SAC_PEND;
        end
      end
      SAC_PEND: begin
        // applied regardless of power enable
        if (sel_rise) begin
          next_word  = pend_word;
          next_state = SAC_IDLE;
        end
      end
      default: next_state = SAC_IDLE;
    endcase
    // active-low weights in half-dB units, saturating at the maximum
    inv_word     = ~next_word;
    next_half_db = (inv_word > ATTEN_MAX) ? ATTEN_MAX : inv_word;
  end

  // core registers; reset presets maximum attenuation
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state           <= SAC_IDLE;
      sel_q           <= 1'b0;
      tog_q           <= 1'b0;
      pend_word       <= WORD_RESET;
      atten_word_o    <= WORD_RESET;
      atten_half_db_o <= ATTEN_MAX;
      amp_on_o        <= 1'b0;
    end else begin
      state           <= next_state;
      sel_q           <= sel_s;
      tog_q           <= (state == SAC_IDLE) ? tog_s : tog_q;
      pend_word       <= next_pend_word;
      atten_word_o    <= next_word;
      atten_half_db_o <= next_half_db;
      amp_on_o        <= pwr_s;
    end
  end

  // =====================================================
  // assertions
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_seen <= 1'b0;
    end else if (state == SAC_PEND && sel_rise) begin
      word_seen <= 1'b1;
    end
  end

  property p_preset;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !word_seen |-> atten_word_o == WORD_RESET;
  endproperty
  a_preset: assert property (p_preset)
    else $error("word changed before any applied write");

  property p_apply_on_rise;
    @(posedge core_clk_i) disable iff (!resetn_i)
      $changed(atten_word_o) |-> $past(sel_rise) && $past(state) == SAC_PEND;
  endproperty
  a_apply_on_rise: assert property (p_apply_on_rise)
    else $error("word changed without select rising edge");

  property p_zero_atten;
    @(posedge core_clk_i) disable iff (!resetn_i)
      atten_word_o == 6'h3F |-> atten_half_db_o == 6'h00;
  endproperty
  a_zero_atten: assert property (p_zero_atten)
    else $error("all ones must give zero attenuation");

  property p_weight;
    @(posedge core_clk_i) disable iff (!resetn_i)
      atten_word_o == 6'h1F |-> atten_half_db_o == 6'h20;
  endproperty
  a_weight: assert property (p_weight)
    else $error("top bit must weigh 16 dB");

  property p_saturate;
    @(posedge core_clk_i) disable iff (!resetn_i)
      atten_word_o <= SAT_CODE |-> atten_half_db_o == ATTEN_MAX;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("low codes must saturate at maximum");

  property p_power;
    @(posedge core_clk_i) disable iff (!resetn_i)
      $changed(pwr_s) |=> amp_on_o == $past(pwr_s);
  endproperty
  a_power: assert property (p_power)
    else $error("amplifier enable did not follow input");

  property p_standby_latch;
    @(posedge core_clk_i) disable iff (!resetn_i)
      state == SAC_PEND && sel_rise && !amp_on_o |=>
        atten_word_o == $past(pend_word);
  endproperty
  a_standby_latch: assert property (p_standby_latch)
    else $error("word not latched during standby");

  property p_sixth_bit;
    @(posedge serial_clk_i) disable iff (!resetn_i)
      bit_cnt == CNT_LAST |=>
        hold_word == {$past(shift[WORD_W-2:0]), $past(serial_data_i)};
  endproperty
  a_sixth_bit: assert property (p_sixth_bit)
    else $error("sixth bit did not complete the word msb first");

  c_apply: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    state == SAC_PEND && sel_rise);
  c_standby: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    state == SAC_PEND && sel_rise && !amp_on_o);
  c_max: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    word_seen && atten_half_db_o == ATTEN_MAX);
endmodule

// File: dv/sac_host_model.sv
// host controller model driving the three-wire serial bus
module sac_host_model (
  output logic sclk_o,
  output logic sdata_o,
  output logic sel_n_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus: select high, clock parked low
  initial begin
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
    sel_n_o = 1'b1;
  end

  // =========================================================
  // frame task: n bits of w, msb first, 30 ns serial clock
  task automatic send(input logic [5:0] w, input int n);
    sel_n_o = 1'b0;
    #11; // select setup; odd offset keeps serial edges off core edges
    for (int i = 0; i < n; i++) begin
      sdata_o = w[5-i];
      #15 sclk_o = 1'b1; // device samples here
      #15 sclk_o = 1'b0; // data moves only after the rise
    end
    sdata_o = ~sdata_o; // released data no longer holds the last bit
    #20 sel_n_o = 1'b1; // trigger pulse ends the frame
    #30; // select stays high before any further clock
  endtask
endmodule

// File: dv/sac_top_tb.sv
// self-checking testbench for the serial attenuation control port
module sac_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sac_pkg::*;

  logic                core_clk_i           = 1'b0;
  logic                resetn_i             = 1'b0;
  logic                power_enable_input_i = 1'b0;
  wire logic           sclk;
  wire logic           sdata;
  wire logic           sel_n;
  logic [WORD_W-1:0]   atten_word;
  logic [WORD_W-1:0]   atten_half_db;
  logic                amp_on;
  int                  fails   = 0;
  int                  checked = 0;

  // 200 MHz core clock
  always #2.5 core_clk_i = ~core_clk_i;

  sac_host_model host_u (
    .sclk_o  (sclk),
    .sdata_o (sdata),
    .sel_n_o (sel_n)
  );

  sac_top dut_u (
    .core_clk_i           (core_clk_i),
    .resetn_i             (resetn_i),
    .serial_clk_i         (sclk),
    .serial_data_i        (sdata),
    .select_bar_input_i   (sel_n),
    .power_enable_input_i (power_enable_input_i),
    .atten_word_o         (atten_word),
    .atten_half_db_o      (atten_half_db),
    .amp_on_o             (amp_on)
  );

  // =========================================================
  // shared helpers
  task automatic chk(input string nm, input logic [5:0] exp,
                     input logic [5:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // send a frame, then let the crossing settle
  task automatic apply(input logic [5:0] w, input int n);
    host_u.send(w, n);
    repeat (8) @(posedge core_clk_i);
  endtask

  // applied word and its expected half-dB attenuation
  task automatic expect_word(input logic [5:0] w, input logic [5:0] db);
    chk("atten_word", w, atten_word);
    chk("atten_half_db", db, atten_half_db);
  endtask

  // change power enable, bounded wait for the amplifier to follow
  task automatic set_power(input logic v);
    int n;
    @(posedge core_clk_i) power_enable_input_i <= v;
    n = 0;
    while (amp_on !== v && n < 10) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("amp_on", {5'h00, v}, {5'h00, amp_on});
    if (amp_on !== v) end_sim(); // follow bound used up
  endtask

  // =========================================================
  // scenarios
  task automatic t_reset;
    chk("atten_word", 6'h00, atten_word);
    chk("atten_half_db", 6'h3B, atten_half_db);
    chk("amp_on", 6'h00, {5'h00, amp_on});
  endtask

  task automatic t_decode;
    logic [5:0] codes [10];
    logic [5:0] dbs [10];
    codes = '{6'h3F, 6'h3E, 6'h3D, 6'h3B, 6'h37, 6'h2F, 6'h1F,
              6'h04, 6'h03, 6'h00};
    // half-dB units taken from the binary weights and the saturation
    dbs   = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20,
              6'h3B, 6'h3B, 6'h3B};
    foreach (codes[i]) begin
      apply(codes[i], 6);
      expect_word(codes[i], dbs[i]);
    end
  endtask

  task automatic t_short;
    apply(6'h2A, 6);
    expect_word(6'h2A, 6'h15);
    apply(6'h15, 5);
    expect_word(6'h2A, 6'h15);
  endtask

  task automatic t_standby;
    set_power(1'b1);
    set_power(1'b0);
    apply(6'h35, 6);
    expect_word(6'h35, 6'h0A);
    set_power(1'b1);
    expect_word(6'h35, 6'h0A);
  endtask

  // =========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_reset();
    t_decode();
    t_short();
    t_standby();
    end_sim();
  end
endmodule
